// ### idc_dma_ctrl.sv
// Seven-channel cascaded ISA DMA controller with upstream hold handshake.
// Assumes an APB master on pclk; dreq and the hold grant arrive from pins.
`timescale 1ns/10ps
`default_nettype none
`include "idc_defines.svh"

// How it works
// - Request raises upstream hold request
// - Acknowledge held off until bus owned
// - Grant sampled before ISA bus handed over
// - Channel four fixed cascade link
// - Seven channels across two controllers
// - Request register bit raises software request
// - Channels 0-3 count bytes
// - Channels 5-7 count words, address shifted
// - Page plus current address gives 24 bits
// - Refresh addresses; autoinit reload on terminal
// - Idle means slave mode, registers answer
// - Master mode: DMA cycles or cascade
// - Memory strobe only below 16 Mbytes
// - System memory strobe only below 1 Mbyte
// - Address enable high during DMA cycles
// - Address latch enable high during DMA
// - Single, block, demand, cascade; no mem-to-mem
// - Read, write, verify in active modes
// - Count down, step address, terminal at wrap
// - Single mode releases bus after each transfer
// - Fast bit selects three-clock timing, buffer
module idc_dma_ctrl #(
    parameter int NCH = 8
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // ISA DMA handshake
    input wire logic [NCH-1:0] dreq,
    output logic [NCH-1:0] dack,
    output logic terminal_count,
    // Upstream arbiter, active low pins
    output logic upstream_hold_request_n,
    input wire logic upstream_hold_grant_n,
    // ISA cycle control
    output logic aen,
    output logic bale,
    output logic [23:0] mem_addr,
    output logic mem_read_n,
    output logic mem_write_n,
    output logic sys_mem_read_n,
    output logic sys_mem_write_n,
    output logic io_read_n,
    output logic io_write_n,
    output logic fast_buffer_flush,
    // Refresh
    input wire logic refresh_tick,
    output logic [15:0] refresh_addr
);
    import idc_pkg::*;

    logic [NCH-1:0] dreq_meta;
    logic [NCH-1:0] dreq_s;
    logic grant_meta;
    logic grant_s;
    logic [15:0] base_addr [NCH];
    logic [15:0] base_cnt [NCH];
    logic [15:0] cur_addr [NCH];
    logic [15:0] cur_cnt [NCH];
    logic [7:0] page [NCH];
    logic [5:0] channel_mode_register [NCH];
    logic [NCH-1:0] sw_req;
    logic [NCH-1:0] mask;
    logic [NCH-1:0] fast_timing_select;
    logic [NCH-1:0] tc_flag;
    idc_state_t state;
    logic [2:0] ch;
    logic [3:0] cyc;
    logic grant_armed;
    logic [2:0] buf_bytes;
    logic [NCH-1:0] pend;
    logic any_pend;
    logic [2:0] win;
    idc_xmode_t xmode;
    idc_xtype_t xtype;
    logic fast;
    logic wide;
    logic [3:0] cyc_last;
    logic xfer_done;
    logic at_tc;
    logic strobe_win;
    logic [24:0] phys;
    logic wr_en;
    logic rd_en;
    logic is_ch;
    logic [2:0] rch;
    logic [2:0] rreg;
    logic mapped;
    logic [31:0] rd_val;

    // Pin inputs through two flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dreq_meta <= '0;
            dreq_s <= '0;
            grant_meta <= 1'b0;
            grant_s <= 1'b0;
        end
        else
        begin
            dreq_meta <= dreq;
            dreq_s <= dreq_meta;
            grant_meta <= ~upstream_hold_grant_n;
            grant_s <= grant_meta;
        end
    end

    // Request pool and fixed priority 0,1,2,3,5,6,7
    always_comb
    begin
        pend = (dreq_s | sw_req) & ~mask;
        pend[`IDC_CASCADE_CH] = 1'b0;
        any_pend = |pend;
        win = 3'h0;
        for (int i = NCH - 1; i >= 0; i--)
        begin
            if (pend[i])
            begin
                win = 3'(i);
            end
        end
    end

    assign xmode = idc_xmode_t'(
        channel_mode_register[ch][`IDC_MODE_XMODE_LSB +: 2]);
    assign xtype = idc_xtype_t'(
        channel_mode_register[ch][`IDC_MODE_TYPE_LSB +: 2]);
    assign fast = fast_timing_select[ch];
    assign wide = ch[2];
    assign cyc_last = fast ? `IDC_FAST_CYCLES - 4'h1 : `IDC_COMPAT_CYCLES - 4'h1;
    assign xfer_done = (state == IDC_ST_XFER) && (cyc == cyc_last);
    assign at_tc = cur_cnt[ch] == 16'h0000;
    assign strobe_win = (state == IDC_ST_XFER) && (cyc != 4'h0)
        && (cyc != cyc_last || fast);

    // Master/slave sequencing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= IDC_ST_SLAVE;
            ch <= 3'h0;
            cyc <= 4'h0;
            grant_armed <= 1'b0;
        end
        else
        begin
            unique case (state)
                IDC_ST_SLAVE:
                begin
                    grant_armed <= 1'b0;
                    if (any_pend)
                    begin
                        state <= IDC_ST_HOLD;
                        ch <= win;
                    end
                end
                IDC_ST_HOLD:
                begin
                    cyc <= 4'h0;
                    // Grant left over from the last tenure must drop first
                    if (!grant_s)
                    begin
                        grant_armed <= 1'b1;
                    end
                    if (grant_s && grant_armed)
                    begin
                        if (xmode == IDC_XM_CASCADE)
                        begin
                            state <= IDC_ST_CASCADE;
                        end
                        else
                        begin
                            state <= IDC_ST_XFER;
                        end
                    end
                end
                IDC_ST_XFER:
                begin
                    cyc <= xfer_done ? 4'h0 : cyc + 4'h1;
                    if (xfer_done)
                    begin
                        if (at_tc || xmode == IDC_XM_SINGLE)
                        begin
                            state <= IDC_ST_SLAVE;
                        end
                        else if (xmode == IDC_XM_DEMAND && !dreq_s[ch])
                        begin
                            state <= IDC_ST_SLAVE;
                        end
                    end
                end
                IDC_ST_CASCADE:
                begin
                    if (!dreq_s[ch])
                    begin
                        state <= IDC_ST_SLAVE;
                    end
                end
            endcase
        end
    end

    // APB decode
    assign rch = paddr[7:5];
    assign rreg = paddr[4:2];
    assign is_ch = paddr[11:8] == 4'h1;
    assign mapped = (paddr[1:0] == 2'b00) && (is_ch ? rreg <= `IDC_REG_MODE
        : (paddr[11:8] == 4'h0 && paddr[7:5] == 3'h0
        && paddr[4:0] <= 5'(`IDC_OFS_REFRESH)));
    assign wr_en = psel && penable && pwrite && mapped;
    assign rd_en = psel && !penable;
    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped;

    // Channel registers and address/count stepping
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NCH; i++)
            begin
                base_addr[i] <= 16'h0000;
                base_cnt[i] <= 16'h0000;
                cur_addr[i] <= 16'h0000;
                cur_cnt[i] <= 16'h0000;
                page[i] <= 8'h00;
                channel_mode_register[i] <= (i == `IDC_CASCADE_CH)
                    ? `IDC_RST_CASCADE_MODE : `IDC_RST_MODE;
            end
        end
        else
        begin
            if (wr_en && is_ch)
            begin
                unique case (rreg)
                    `IDC_REG_BASE_ADDR:
                    begin
                        base_addr[rch] <= pwdata[15:0];
                        cur_addr[rch] <= pwdata[15:0];
                    end
                    `IDC_REG_BASE_CNT:
                    begin
                        base_cnt[rch] <= pwdata[15:0];
                        cur_cnt[rch] <= pwdata[15:0];
                    end
                    `IDC_REG_PAGE: page[rch] <= pwdata[7:0];
                    `IDC_REG_MODE:
                    begin
                        if (rch != `IDC_CASCADE_CH)
                        begin
                            channel_mode_register[rch] <= pwdata[5:0];
                        end
                    end
                    default:
                    begin
                    end
                endcase
            end
            if (xfer_done)
            begin
                if (at_tc && channel_mode_register[ch][`IDC_MODE_AUTOINIT_BIT])
                begin
                    cur_addr[ch] <= base_addr[ch];
                    cur_cnt[ch] <= base_cnt[ch];
                end
                else
                begin
                    cur_cnt[ch] <= cur_cnt[ch] - 16'h0001;
                    if (channel_mode_register[ch][`IDC_MODE_DEC_BIT])
                    begin
                        cur_addr[ch] <= cur_addr[ch] - 16'h0001;
                    end
                    else
                    begin
                        cur_addr[ch] <= cur_addr[ch] + 16'h0001;
                    end
                end
            end
        end
    end

    // Global control; hardware set wins over software clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sw_req <= '0;
            mask <= `IDC_RST_MASK;
            fast_timing_select <= '0;
            tc_flag <= '0;
        end
        else
        begin
            if (wr_en && !is_ch && paddr[4:0] == 5'(`IDC_OFS_REQUEST))
            begin
                sw_req <= sw_req | pwdata[NCH-1:0];
            end
            else if (xfer_done && at_tc)
            begin
                sw_req[ch] <= 1'b0;
            end
            if (wr_en && !is_ch && paddr[4:0] == 5'(`IDC_OFS_MASK))
            begin
                mask <= pwdata[NCH-1:0];
            end
            if (xfer_done && at_tc
                && !channel_mode_register[ch][`IDC_MODE_AUTOINIT_BIT])
            begin
                mask[ch] <= 1'b1;
            end
            if (wr_en && !is_ch && paddr[4:0] == 5'(`IDC_OFS_FAST))
            begin
                fast_timing_select <= pwdata[NCH-1:0];
            end
            if (wr_en && !is_ch && paddr[4:0] == 5'(`IDC_OFS_STATUS))
            begin
                tc_flag <= tc_flag & ~pwdata[NCH-1:0];
            end
            if (xfer_done && at_tc)
            begin
                tc_flag[ch] <= 1'b1;
            end
        end
    end

    // Refresh address generation
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            refresh_addr <= 16'h0000;
        end
        else if (refresh_tick)
        begin
            refresh_addr <= refresh_addr + 16'h0001;
        end
    end

    // Fast buffer: gather four bytes, or reach terminal count, before a flush
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            buf_bytes <= 3'h0;
            fast_buffer_flush <= 1'b0;
        end
        else
        begin
            fast_buffer_flush <= 1'b0;
            if (xfer_done && fast)
            begin
                if (buf_bytes + (wide ? 3'h2 : 3'h1) >= `IDC_FAST_BUF_BYTES
                    || at_tc)
                begin
                    buf_bytes <= 3'h0;
                    fast_buffer_flush <= 1'b1;
                end
                else
                begin
                    buf_bytes <= buf_bytes + (wide ? 3'h2 : 3'h1);
                end
            end
        end
    end

    // Read data captured in the setup phase
    always_comb
    begin
        rd_val = 32'h0000_0000;
        if (is_ch)
        begin
            unique case (rreg)
                `IDC_REG_BASE_ADDR: rd_val = {16'h0000, base_addr[rch]};
                `IDC_REG_BASE_CNT: rd_val = {16'h0000, base_cnt[rch]};
                `IDC_REG_CUR_ADDR: rd_val = {16'h0000, cur_addr[rch]};
                `IDC_REG_CUR_CNT: rd_val = {16'h0000, cur_cnt[rch]};
                `IDC_REG_PAGE: rd_val = {24'h000000, page[rch]};
                `IDC_REG_MODE: rd_val = {26'h0, channel_mode_register[rch]};
                default: rd_val = 32'h0000_0000;
            endcase
        end
        else
        begin
            unique case (paddr[4:0])
                5'(`IDC_OFS_REQUEST): rd_val = {24'h000000, sw_req};
                5'(`IDC_OFS_MASK): rd_val = {24'h000000, mask};
                5'(`IDC_OFS_FAST): rd_val = {24'h000000, fast_timing_select};
                5'(`IDC_OFS_STATUS): rd_val = {14'h0000,
                    state != IDC_ST_SLAVE, state == IDC_ST_XFER
                    || state == IDC_ST_CASCADE, pend, tc_flag};
                5'(`IDC_OFS_REFRESH): rd_val = {16'h0000, refresh_addr};
                default: rd_val = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (rd_en)
        begin
            prdata <= mapped ? rd_val : 32'h0000_0000;
        end
    end

    // ISA side outputs
    assign upstream_hold_request_n = state == IDC_ST_SLAVE;
    always_comb
    begin
        dack = '0;
        if (state == IDC_ST_XFER || state == IDC_ST_CASCADE)
        begin
            dack[ch] = 1'b1;
        end
    end
    assign terminal_count = xfer_done && at_tc;
    assign aen = state == IDC_ST_XFER;
    assign bale = state == IDC_ST_XFER || state == IDC_ST_CASCADE;
    assign phys = wide ? {1'b0, page[ch][7:1], cur_addr[ch], 1'b0}
        : {1'b0, page[ch], cur_addr[ch]};
    assign mem_addr = phys[23:0];
    assign mem_read_n = !(strobe_win && xtype == IDC_XT_READ
        && !phys[24]);
    assign mem_write_n = !(strobe_win && xtype == IDC_XT_WRITE && !phys[24]);
    assign sys_mem_read_n = !(strobe_win && xtype == IDC_XT_READ
        && phys[24:20] == 5'h00);
    assign sys_mem_write_n = !(strobe_win && xtype == IDC_XT_WRITE
        && phys[24:20] == 5'h00);
    assign io_write_n = mem_read_n;
    assign io_read_n = mem_write_n;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_hold_on_request: assert property (
        (state == IDC_ST_SLAVE && any_pend) |=> !upstream_hold_request_n)
        else $error("hold not raised");
    a_dack_after_grant: assert property (
        $rose(|dack) |-> $past(grant_s))
        else $error("ack before grant");
    a_ch4_cascade: assert property (
        channel_mode_register[`IDC_CASCADE_CH] == `IDC_RST_CASCADE_MODE
        && !dack[`IDC_CASCADE_CH])
        else $error("channel four left cascade");
    a_aen_bale_dma: assert property (
        state == IDC_ST_XFER |-> aen && bale)
        else $error("aen or bale low in dma");
    a_single_release: assert property (
        (xfer_done && xmode == IDC_XM_SINGLE)
        |=> upstream_hold_request_n && dack == '0)
        else $error("single mode kept bus");
    a_tc_wrap: assert property (
        (xfer_done && at_tc
        && !channel_mode_register[ch][`IDC_MODE_AUTOINIT_BIT])
        |=> cur_cnt[$past(ch)] == 16'hFFFF)
        else $error("no wrap");
    a_sys_below_1m: assert property (
        !sys_mem_read_n || !sys_mem_write_n |-> mem_addr[23:20] == 4'h0)
        else $error("sys strobe high");
    a_cycle_length: assert property (
        $rose(state == IDC_ST_XFER) && !fast |-> ##7 xfer_done)
        else $error("compat length wrong");
    a_verify_quiet: assert property (
        xtype == IDC_XT_VERIFY |-> mem_read_n && mem_write_n)
        else $error("verify strobed");
    c_single: cover property (xfer_done && xmode == IDC_XM_SINGLE);
    c_cascade: cover property (state == IDC_ST_CASCADE
        ##1 state == IDC_ST_SLAVE);
    c_autoinit: cover property (terminal_count
        && channel_mode_register[ch][`IDC_MODE_AUTOINIT_BIT]);
    c_fast_flush: cover property (fast_buffer_flush);

endmodule : idc_dma_ctrl
`default_nettype wire

// ### idc_defines.svh
// Constants of the ISA DMA controller block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package and the controller module.
`ifndef IDC_DEFINES_SVH
`define IDC_DEFINES_SVH

// Global registers (byte offsets)
`define IDC_OFS_REQUEST 12'h000
`define IDC_OFS_MASK 12'h004
`define IDC_OFS_FAST 12'h008
`define IDC_OFS_STATUS 12'h00C
`define IDC_OFS_REFRESH 12'h010
// Channel block: base + channel * stride + register
`define IDC_OFS_CH_BASE 12'h100
`define IDC_CH_STRIDE 12'h020
`define IDC_REG_BASE_ADDR 3'h0
`define IDC_REG_BASE_CNT 3'h1
`define IDC_REG_CUR_ADDR 3'h2
`define IDC_REG_CUR_CNT 3'h3
`define IDC_REG_PAGE 3'h4
`define IDC_REG_MODE 3'h5

// Mode register fields
`define IDC_MODE_TYPE_LSB 0
`define IDC_MODE_AUTOINIT_BIT 2
`define IDC_MODE_DEC_BIT 3
`define IDC_MODE_XMODE_LSB 4
// Status register fields
`define IDC_STAT_TC_LSB 0
`define IDC_STAT_REQ_LSB 8
`define IDC_STAT_MASTER_BIT 16
`define IDC_STAT_HOLD_BIT 17

// Reset values
`define IDC_RST_MASK 8'hFF
`define IDC_RST_MODE 6'h00
`define IDC_RST_CASCADE_MODE 6'h30

// Timing in SYSCLK periods (pclk serves as SYSCLK), fast buffer size, cascade channel
`define IDC_COMPAT_CYCLES 4'h8
`define IDC_FAST_CYCLES 4'h3
`define IDC_FAST_BUF_BYTES 3'h4
`define IDC_CASCADE_CH 3'h4

`endif

// ### idc_pkg.sv
// Types of the ISA DMA controller block.
// Assumes idc_defines.svh sits in the include path.
`default_nettype none
`include "idc_defines.svh"

package idc_pkg;

    typedef enum logic [1:0] {
        IDC_ST_SLAVE = 2'b00,
        IDC_ST_HOLD = 2'b01,
        IDC_ST_XFER = 2'b10,
        IDC_ST_CASCADE = 2'b11
    } idc_state_t;

    typedef enum logic [1:0] {
        IDC_XM_DEMAND = 2'b00,
        IDC_XM_SINGLE = 2'b01,
        IDC_XM_BLOCK = 2'b10,
        IDC_XM_CASCADE = 2'b11
    } idc_xmode_t;

    typedef enum logic [1:0] {
        IDC_XT_VERIFY = 2'b00,
        IDC_XT_WRITE = 2'b01,
        IDC_XT_READ = 2'b10,
        IDC_XT_ILLEGAL = 2'b11
    } idc_xtype_t;

endpackage : idc_pkg
`default_nettype wire

// ### idc_arb_model.sv
// Upstream bus arbiter model: grants the hold after a chosen delay.
// Assumes active-low request and grant lines on the controller's clock.
`timescale 1ns/10ps
`default_nettype none
module idc_arb_model #(
    parameter int GRANT_DELAY = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Prompt or slow answer
    input wire logic slow_mode,
    // Hold handshake
    input wire logic upstream_hold_request_n,
    output logic upstream_hold_grant_n
);
    int wait_cnt;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_cnt <= 0;
            upstream_hold_grant_n <= 1'b1;
        end
        else if (upstream_hold_request_n)
        begin
            wait_cnt <= 0;
            upstream_hold_grant_n <= 1'b1;
        end
        else if (slow_mode && wait_cnt < GRANT_DELAY)
            wait_cnt <= wait_cnt + 1;
        else
            upstream_hold_grant_n <= 1'b0;
    end
endmodule : idc_arb_model
`default_nettype wire

// ### idc_dma_ctrl_tb.sv
// Bench for the DMA controller: APB tasks and DMA transfer scenarios.
// Assumes idc_pkg, idc_defines.svh and the arbiter model are compiled.
`timescale 1ns/10ps
`default_nettype none
`include "idc_defines.svh"
module idc_dma_ctrl_tb;
    import idc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, perr, tc, hreq_n, hgnt_n, aen, bale;
    logic mr_n, mw_n, smr_n, smw_n, ior_n, iow_n, flush;
    logic [7:0] dreq = 8'h00;
    logic [7:0] dack, act;
    logic slow = 1'b0;
    logic refresh_tick = 1'b0;
    logic [15:0] refresh_addr, r0;
    logic [23:0] mem_addr;
    int n_fail = 0;
    int check_count = 0;
    int cnt [8] = '{default: 0};
    int base [8] = '{default: 0};

    always #4 pclk = ~pclk;

    // Cycle counts of strobes, terminal count and flush
    assign act = {flush, tc, ~iow_n, ~ior_n, ~smw_n, ~smr_n, ~mw_n, ~mr_n};
    always @(posedge pclk)
        for (int i = 0; i < 8; i++)
            cnt[i] += (act[i] === 1'b1);

    idc_dma_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .dreq(dreq),
        .dack(dack), .terminal_count(tc), .upstream_hold_request_n(hreq_n),
        .upstream_hold_grant_n(hgnt_n), .aen(aen), .bale(bale),
        .mem_addr(mem_addr), .mem_read_n(mr_n), .mem_write_n(mw_n),
        .sys_mem_read_n(smr_n), .sys_mem_write_n(smw_n), .io_read_n(ior_n),
        .io_write_n(iow_n), .fast_buffer_flush(flush),
        .refresh_tick(refresh_tick), .refresh_addr(refresh_addr));
    idc_arb_model arb_u (.pclk(pclk), .presetn(presetn), .slow_mode(slow),
        .upstream_hold_request_n(hreq_n), .upstream_hold_grant_n(hgnt_n));

    task automatic finish_test;
        $display("mismatches %0d checks %0d", n_fail, check_count);
        if (n_fail == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            n_fail++;
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
        begin
            n_fail++;
            finish_test();
        end
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rdc

    function automatic logic [11:0] ra(input int c, input int r);
        return 12'(`IDC_OFS_CH_BASE + c * `IDC_CH_STRIDE + r * 4);
    endfunction : ra

    // Bounded wait for a dack bit (0..7) or the hold request (8)
    task automatic wt(input int s, input logic lvl);
        int i;
        for (i = 0; i < 300; i++)
        begin
            @(posedge pclk);
            if (((s == 8) ? hreq_n : dack[s]) === lvl)
                break;
        end
        if (i == 300)
        begin
            n_fail++;
            finish_test();
        end
    endtask : wt

    task automatic dchk(input int e [8]);
        repeat (2) @(posedge pclk);
        for (int i = 0; i < 8; i++)
            chk(cnt[i] - base[i], e[i]);
        base = cnt;
    endtask : dchk

    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdc(ra(4, 5), 32'h30);
        rdc(`IDC_OFS_MASK, 32'hFF);
        wr(ra(4, 5), 32'h00);
        rdc(ra(4, 5), 32'h30);
        rdc(12'hFFC, 32'h0);
        chk(perr, 1'b1);
        rdc(`IDC_OFS_STATUS, 32'h0);
        // Single read, channel 1, slow grant
        slow <= 1'b1;
        wr(ra(1, 0), 32'h1234);
        wr(ra(1, 1), 32'h1);
        wr(ra(1, 4), 32'h05);
        wr(ra(1, 5), 32'h12);
        wr(`IDC_OFS_MASK, 32'hFD);
        base = cnt;
        dreq[1] <= 1'b1;
        wt(8, 1'b0);
        repeat (3)
        begin
            chk(dack, 8'h00);
            @(posedge pclk);
        end
        wt(1, 1'b1);
        chk({aen, bale}, 2'b11);
        chk(mem_addr, 24'h051234);
        wt(1, 1'b0);
        chk(hreq_n, 1'b1);
        wt(1, 1'b1);
        chk(mem_addr, 24'h051235);
        chk(hgnt_n, 1'b0);
        wt(1, 1'b0);
        dreq[1] <= 1'b0;
        dchk('{12, 0, 12, 0, 0, 12, 1, 0});
        rdc(ra(1, 3), 32'hFFFF);
        rdc(ra(1, 2), 32'h1236);
        rdc(`IDC_OFS_MASK, 32'hFF);
        rdc(`IDC_OFS_STATUS, 32'h02);
        // Block write, channel 5, software request, autoinit
        slow <= 1'b0;
        wr(ra(5, 0), 32'h0100);
        wr(ra(5, 1), 32'h1);
        wr(ra(5, 4), 32'h20);
        wr(ra(5, 5), 32'h25);
        wr(`IDC_OFS_MASK, 32'hDF);
        wr(`IDC_OFS_REQUEST, 32'h20);
        wt(5, 1'b1);
        chk(mem_addr, 24'h200200);
        wt(5, 1'b0);
        dchk('{0, 12, 0, 0, 12, 0, 1, 0});
        rdc(ra(5, 3), 32'h1);
        rdc(ra(5, 2), 32'h100);
        rdc(`IDC_OFS_MASK, 32'hDF);
        // Fast demand write, channel 0, low memory forwarded upstream
        wr(`IDC_OFS_FAST, 32'h01);
        wr(ra(0, 0), 32'h0040);
        wr(ra(0, 1), 32'h0);
        wr(ra(0, 4), 32'h0);
        wr(ra(0, 5), 32'h01);
        wr(`IDC_OFS_MASK, 32'hDE);
        dreq[0] <= 1'b1;
        wt(0, 1'b1);
        wt(0, 1'b0);
        dreq[0] <= 1'b0;
        dchk('{0, 2, 0, 2, 2, 0, 1, 1});
        // Single verify, channel 2, then cascade on channel 6
        wr(ra(2, 5), 32'h18);
        wr(ra(6, 5), 32'h30);
        wr(`IDC_OFS_MASK, 32'h9B);
        wr(`IDC_OFS_REQUEST, 32'h04);
        wt(2, 1'b1);
        wt(2, 1'b0);
        dchk('{0, 0, 0, 0, 0, 0, 1, 0});
        rdc(ra(2, 2), 32'hFFFF);
        dreq[6] <= 1'b1;
        wt(6, 1'b1);
        chk({aen, bale}, 2'b01);
        dreq[6] <= 1'b0;
        wt(6, 1'b0);
        dchk('{0, 0, 0, 0, 0, 0, 0, 0});
        // Refresh address steps once per cycle with tick high
        @(posedge pclk);
        r0 = refresh_addr;
        refresh_tick <= 1'b1;
        repeat (3) @(posedge pclk);
        refresh_tick <= 1'b0;
        @(posedge pclk);
        chk(refresh_addr, 16'(r0 + 16'h3));
        finish_test();
    end
endmodule : idc_dma_ctrl_tb
`default_nettype wire
